/* hdl/gsm_pkg.sv */
package gsm_pkg;
	// register byte offsets on the avalon slave
	localparam logic [4:0] OFS_ENABLE = 5'h00;
	localparam logic [4:0] OFS_CONTROL = 5'h04;
	localparam logic [4:0] OFS_STATUS = 5'h08;
	localparam logic [4:0] OFS_TX_DATA = 5'h0c;
	localparam logic [4:0] OFS_RX_DATA = 5'h10;
	localparam logic [4:0] OFS_CLK_CTRL = 5'h14;
	localparam logic [4:0] OFS_CLK_DIV = 5'h18;

	// control register fields
	localparam int CTL_LSB_FIRST = 0;
	localparam int CTL_IN_SEL_LO = 1;
	localparam int CTL_IN_SEL_HI = 2;
	localparam int CTL_BIOEN = 3;
	localparam int CTL_SOFT_RESET = 4;
	localparam int CTL_AUTO_READ = 5;

	// clock control register fields
	localparam int CCK_TX_PHASE = 0;
	localparam int CCK_RX_PHASE = 1;
	localparam int CCK_POLARITY = 2;
	localparam int CCK_SRC_DIV32 = 3;

	// status register fields
	localparam int STS_TX_EMPTY = 0;
	localparam int STS_RX_FULL = 1;
	localparam int STS_BUSY = 2;

	// receive path selection
	localparam logic [1:0] SEL_FULL = 2'h0;
	localparam logic [1:0] SEL_HALF = 2'h1;
	localparam logic [1:0] SEL_DUAL = 2'h2;

	// reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_CLK_CTRL = 8'h00;
	localparam logic [5:0] RST_CLK_DIV = 6'h00;
	localparam logic [7:0] RST_DATA = 8'h00;

	// edges per byte, single line and dual receive
	localparam logic [4:0] EDGES_SINGLE = 5'h10;
	localparam logic [4:0] EDGES_DUAL = 5'h08;

	// engine states
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_SHIFT = 1'b1
	} gsm_state_type;
endpackage

/* hdl/gsm_spi_master.sv */
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
// Behaviour
// - master only; generates clock; full, half duplex and dual read modes
// - data moves through 8-bit shift registers, one bit per serial clock period, two in dual receive
// - out pin driven in full duplex, bidirectional in half duplex
// - dual read data phase samples out pin as second input
// - half duplex ignores the dedicated input pin
// - master drives serial clock; data shifted and sampled per phase, polarity
// - serial clock from 6-bit down counter, core clock or div32 strobe
// - register access happens on the bus clock
// - after power reset the block is disabled, control at reset values
// - soft reset bit returns control logic to the power reset state
// - transmit empty and receive full drive interrupt event outputs
// - flash instance drives dma write and read requests from status
// - enabled and awake: normal operation, clock request high
// - disabled or sleeping mid-transfer: request held until idle
// - disabled: clock gated, out and clock pins at inactive levels
// - sleep: finish transfer, park pins, drop clock request
// - msb first or lsb first selectable
// - serial clock polarity selectable
// - transmit phase selects presenting edge
// - programmable serial clock frequency
// - transfers start on transmit data write, or on rx data read with auto read set
// - tx data write clears empty; load into shifter sets it
// - direction output 0 drives from shifter, 1 receives on path two
// - dual receive: even bits from out pin, odd from in pin
module gsm_spi_master #(
	parameter bit FLASH_INSTANCE = 1'b1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// power management
	input wire logic sleep_request,
	output logic core_clock_request,
	// serial pins
	output logic serial_clock_pin,
	output logic serial_out_pin,
	output logic out_pin_direction,
	input wire logic receive_path_one,
	input wire logic receive_path_two,
	input wire logic core_div32_strobe,
	// events and dma
	output logic tx_empty_event,
	output logic rx_full_event,
	output logic dma_write_request,
	output logic dma_read_request
);

	gsm_pkg::gsm_state_type state_r;
	logic ack_r;
	logic srst_r;
	logic rst_any;
	logic acc_rd;
	logic acc_wr;
	logic [31:0] rd_val;
	logic enable_r;
	logic [7:0] control_r;
	logic [7:0] clk_ctrl_r;
	logic [5:0] clk_div_r;
	logic [7:0] tx_hold_r;
	logic tx_full_r;
	logic [7:0] rx_data_r;
	logic rx_full_r;
	logic [5:0] div_cnt_r;
	logic [4:0] edge_cnt_r;
	logic sck_r;
	logic out_r;
	logic [7:0] tx_sh_r;
	logic [7:0] rx_sh_r;
	logic run_ok;
	logic busy;
	logic parked;
	logic tick;
	logic edge_ev;
	logic leading;
	logic sample_now;
	logic present_now;
	logic last_edge;
	logic load_now;
	logic lsb_first;
	logic [1:0] in_sel;
	logic bioen;
	logic dual_rx;
	logic drive_out;
	logic rx_bit;
	logic [4:0] n_edges;
	logic [7:0] rx_shift_val;
	logic [7:0] tx_first;

	// field views
	assign lsb_first = control_r[gsm_pkg::CTL_LSB_FIRST];
	assign in_sel = control_r[gsm_pkg::CTL_IN_SEL_HI:gsm_pkg::CTL_IN_SEL_LO];
	assign bioen = control_r[gsm_pkg::CTL_BIOEN];
	assign dual_rx = (in_sel == gsm_pkg::SEL_DUAL) && !bioen;
	assign n_edges = dual_rx ? gsm_pkg::EDGES_DUAL : gsm_pkg::EDGES_SINGLE;

	// bus handshake: one wait cycle per access, single clock domain
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign acc_rd = avs_read && ack_r;
	assign acc_wr = avs_write && ack_r && avs_byteenable[0];
	assign rst_any = !nrst || srst_r;

	// wait-state toggle
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
		end
	end

	// soft reset pulse, self clearing
	always_ff @(posedge clk_sys) begin
		if (!nrst || srst_r) begin
			srst_r <= 1'b0;
		end else begin
			srst_r <= acc_wr && (avs_address == gsm_pkg::OFS_CONTROL) &&
				avs_writedata[gsm_pkg::CTL_SOFT_RESET];
		end
	end

	// configuration registers
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			enable_r <= 1'b0;
			control_r <= gsm_pkg::RST_CONTROL;
			clk_ctrl_r <= gsm_pkg::RST_CLK_CTRL;
			clk_div_r <= gsm_pkg::RST_CLK_DIV;
		end else if (acc_wr) begin
			case (avs_address)
				gsm_pkg::OFS_ENABLE: enable_r <= avs_writedata[0];
				gsm_pkg::OFS_CONTROL: begin
					control_r <= avs_writedata[7:0] &
						~(8'h01 << gsm_pkg::CTL_SOFT_RESET);
				end
				gsm_pkg::OFS_CLK_CTRL: clk_ctrl_r <= avs_writedata[7:0] & 8'h0f;
				gsm_pkg::OFS_CLK_DIV: clk_div_r <= avs_writedata[5:0];
				default: enable_r <= enable_r;
			endcase
		end
	end

	// read mux, unmapped offsets read zero
	always_comb begin
		rd_val = 32'h0000_0000;
		case (avs_address)
			gsm_pkg::OFS_ENABLE: rd_val[0] = enable_r;
			gsm_pkg::OFS_CONTROL: rd_val[7:0] = control_r;
			gsm_pkg::OFS_STATUS: begin
				rd_val[gsm_pkg::STS_TX_EMPTY] = !tx_full_r;
				rd_val[gsm_pkg::STS_RX_FULL] = rx_full_r;
				rd_val[gsm_pkg::STS_BUSY] = busy;
			end
			gsm_pkg::OFS_TX_DATA: rd_val[7:0] = tx_hold_r;
			gsm_pkg::OFS_RX_DATA: rd_val[7:0] = rx_data_r;
			gsm_pkg::OFS_CLK_CTRL: rd_val[7:0] = clk_ctrl_r;
			gsm_pkg::OFS_CLK_DIV: rd_val[5:0] = clk_div_r;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// registered read data
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			avs_readdata <= 32'h0000_0000;
		end else if ((avs_read || avs_write) && !ack_r) begin
			avs_readdata <= rd_val;
		end
	end

	// engine may start a byte only when enabled and awake
	assign run_ok = enable_r && !sleep_request;
	assign busy = (state_r == gsm_pkg::ST_SHIFT) || (tx_full_r && run_ok);
	assign parked = !busy && !run_ok;
	assign core_clock_request = run_ok || (state_r == gsm_pkg::ST_SHIFT);
	assign load_now = tx_full_r && run_ok &&
		((state_r == gsm_pkg::ST_IDLE) || (edge_ev && last_edge));

	// transmit holding register
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			tx_hold_r <= gsm_pkg::RST_DATA;
		end else if (acc_wr && avs_address == gsm_pkg::OFS_TX_DATA) begin
			tx_hold_r <= avs_writedata[7:0];
		end
	end

	// transmit empty flag; a refill wins over the load
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			tx_full_r <= 1'b0;
		end else if (acc_wr && avs_address == gsm_pkg::OFS_TX_DATA) begin
			tx_full_r <= 1'b1;
		end else if (acc_rd && avs_address == gsm_pkg::OFS_RX_DATA &&
			control_r[gsm_pkg::CTL_AUTO_READ]) begin
			tx_full_r <= 1'b1;
		end else if (load_now) begin
			tx_full_r <= 1'b0;
		end
	end

	// clock divider tick source
	assign tick = clk_ctrl_r[gsm_pkg::CCK_SRC_DIV32] ? core_div32_strobe : 1'b1;
	assign edge_ev = (state_r == gsm_pkg::ST_SHIFT) && tick &&
		(div_cnt_r == 6'h00);
	assign leading = !edge_cnt_r[0];
	assign last_edge = (edge_cnt_r == n_edges - 5'h01);
	assign sample_now = edge_ev &&
		(leading == !clk_ctrl_r[gsm_pkg::CCK_RX_PHASE]);
	assign present_now = edge_ev && !last_edge &&
		(leading == clk_ctrl_r[gsm_pkg::CCK_TX_PHASE]);

	// receive bit source per mode
	always_comb begin
		rx_bit = receive_path_one;
		if (in_sel == gsm_pkg::SEL_HALF) begin
			rx_bit = receive_path_two;
		end
	end

	// receive shift value, one or two bits per sample
	always_comb begin
		rx_shift_val = rx_sh_r;
		if (dual_rx) begin
			if (lsb_first) begin
				rx_shift_val = {receive_path_one, receive_path_two,
					rx_sh_r[7:2]};
			end else begin
				rx_shift_val = {rx_sh_r[5:0], receive_path_one,
					receive_path_two};
			end
		end else if (lsb_first) begin
			rx_shift_val = {rx_bit, rx_sh_r[7:1]};
		end else begin
			rx_shift_val = {rx_sh_r[6:0], rx_bit};
		end
	end

	// with transmit phase 0, first bit leaves the holding register at load
	assign tx_first = lsb_first ? {1'b0, tx_hold_r[7:1]} :
		{tx_hold_r[6:0], 1'b0};

	// engine state
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			state_r <= gsm_pkg::ST_IDLE;
		end else begin
			case (state_r)
				gsm_pkg::ST_IDLE: begin
					if (load_now) begin
						state_r <= gsm_pkg::ST_SHIFT;
					end
				end
				gsm_pkg::ST_SHIFT: begin
					if (edge_ev && last_edge && !load_now) begin
						state_r <= gsm_pkg::ST_IDLE;
					end
				end
				default: begin
					state_r <= gsm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// divider and edge counter
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			div_cnt_r <= gsm_pkg::RST_CLK_DIV;
			edge_cnt_r <= 5'h00;
			sck_r <= 1'b0;
		end else if (load_now) begin
			div_cnt_r <= clk_div_r;
			edge_cnt_r <= 5'h00;
			sck_r <= 1'b0;
		end else if (state_r == gsm_pkg::ST_SHIFT && tick) begin
			if (div_cnt_r == 6'h00) begin
				div_cnt_r <= clk_div_r;
				edge_cnt_r <= edge_cnt_r + 5'h01;
				sck_r <= !sck_r;
			end else begin
				div_cnt_r <= div_cnt_r - 6'h01;
			end
		end
	end

	// transmit shifter and output bit
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			tx_sh_r <= gsm_pkg::RST_DATA;
			out_r <= 1'b0;
		end else if (load_now) begin
			if (clk_ctrl_r[gsm_pkg::CCK_TX_PHASE]) begin
				tx_sh_r <= tx_hold_r;
			end else begin
				tx_sh_r <= tx_first;
				out_r <= lsb_first ? tx_hold_r[0] : tx_hold_r[7];
			end
		end else if (present_now) begin
			out_r <= lsb_first ? tx_sh_r[0] : tx_sh_r[7];
			tx_sh_r <= lsb_first ? {1'b0, tx_sh_r[7:1]} :
				{tx_sh_r[6:0], 1'b0};
		end
	end

	// receive shifter
	always_ff @(posedge clk_sys) begin
		if (rst_any || load_now) begin
			rx_sh_r <= gsm_pkg::RST_DATA;
		end else if (sample_now) begin
			rx_sh_r <= rx_shift_val;
		end
	end

	// receive data register, loaded at the last edge of the byte
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			rx_data_r <= gsm_pkg::RST_DATA;
		end else if (edge_ev && last_edge) begin
			rx_data_r <= sample_now ? rx_shift_val : rx_sh_r;
		end
	end

	// receive full flag; a new byte wins over the read that clears it
	always_ff @(posedge clk_sys) begin
		if (rst_any) begin
			rx_full_r <= 1'b0;
		end else if (edge_ev && last_edge) begin
			rx_full_r <= 1'b1;
		end else if (acc_rd && avs_address == gsm_pkg::OFS_RX_DATA) begin
			rx_full_r <= 1'b0;
		end
	end

	// out pin direction per mode, low while driving
	assign drive_out = (in_sel == gsm_pkg::SEL_FULL) || bioen;

	// pins, parked at inactive levels when idle and disabled or asleep
	always_comb begin
		serial_clock_pin = clk_ctrl_r[gsm_pkg::CCK_POLARITY];
		serial_out_pin = 1'b0;
		out_pin_direction = 1'b0;
		if (!parked) begin
			serial_clock_pin = sck_r ^ clk_ctrl_r[gsm_pkg::CCK_POLARITY];
			serial_out_pin = drive_out ? out_r : 1'b0;
			out_pin_direction = !drive_out;
		end
	end

	// status events and dma requests
	assign tx_empty_event = !tx_full_r;
	assign rx_full_event = rx_full_r;
	assign dma_write_request = FLASH_INSTANCE && !tx_full_r;
	assign dma_read_request = FLASH_INSTANCE && rx_full_r;

endmodule // gsm_spi_master

/* verif/gsm_checker.sv */
`timescale 1ns/1ns
module gsm_checker #(
	parameter bit FLASH_INSTANCE = 1'b1
) (
	// clock, reset and bus
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	// pins and events
	input wire logic core_clock_request,
	input wire logic serial_clock_pin,
	input wire logic serial_out_pin,
	input wire logic tx_empty_event,
	input wire logic rx_full_event,
	input wire logic dma_write_request,
	input wire logic dma_read_request
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// one wait cycle, then the answer
	sequence s_acc;
		(avs_read || avs_write) && avs_waitrequest ##1 !avs_waitrequest;
	endsequence
	AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |-> s_acc)
		else $error("access not answered after one wait");
	AST_WAIT_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("waitrequest without request");
	AST_DMA_WR: assert property (dma_write_request == (FLASH_INSTANCE && tx_empty_event))
		else $error("dma write request differs from tx empty");
	AST_DMA_RD: assert property (dma_read_request == (FLASH_INSTANCE && rx_full_event))
		else $error("dma read request differs from rx full");
	AST_PARK_OUT: assert property (!core_clock_request |-> !serial_out_pin)
		else $error("out pin not parked");
	AST_SCK_REQ: assert property ($changed(serial_clock_pin) && !$past(avs_write) |-> $past(core_clock_request))
		else $error("clock toggles without clock request");
	AST_RX_HOLD: assert property (rx_full_event && !avs_read && !avs_write && !$past(avs_write) |=> rx_full_event)
		else $error("rx full dropped without read");
	AST_TX_CLR: assert property (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == gsm_pkg::OFS_TX_DATA |=> !tx_empty_event)
		else $error("tx empty not cleared by write");
endmodule // gsm_checker
bind gsm_spi_master gsm_checker #(.FLASH_INSTANCE(FLASH_INSTANCE)) gsm_checker_inst (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_waitrequest, .core_clock_request, .serial_clock_pin, .serial_out_pin, .tx_empty_event, .rx_full_event, .dma_write_request, .dma_read_request);

/* verif/gsm_slave_model.sv */
`timescale 1ns/1ns
// behavioural serial flash: polarity 0, trailing-edge launch, msb first
module gsm_slave_model (
	// link side
	input wire logic sck,
	input wire logic mosi,
	// bench control
	input wire logic arm,
	input wire logic dual,
	input wire logic [7:0] reply,
	// answers
	output logic o1,
	output logic o2,
	output logic [7:0] got
);
	logic [3:0] idx;
	// bit index advances on trailing clock edges; arm restarts a frame
	always @(posedge arm or negedge sck) begin
		if (arm) idx <= 4'h0;
		else idx <= idx + 4'h1;
	end
	// capture what the master shifts out on leading edges
	always @(posedge sck) got <= {got[6:0], mosi};
	// dual: odd bits on path one, even on path two; spent lines invert
	always_comb begin
		if (dual) begin
			o1 = idx > 4'h3 ? ~reply[1] : reply[3'h7 - {idx[1:0], 1'b0}];
			o2 = idx > 4'h3 ? ~reply[0] : reply[3'h6 - {idx[1:0], 1'b0}];
		end else begin
			o1 = idx > 4'h7 ? ~reply[0] : reply[3'h7 - idx[2:0]];
			o2 = o1;
		end
	end
endmodule // gsm_slave_model

/* verif/tb.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("BAD %0t mismatch line %0d", $time, `__LINE__); end end
module tb;
	logic clk_sys = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
	logic avs_waitrequest, sleep_request = 1'b0, ccr, sck, sout, dir, txe, rxf;
	logic div32 = 1'b0, arm = 1'b0, dual = 1'b0, half = 1'b0, o1, o2, pin;
	logic pol = 1'b0;
	logic [7:0] reply = 8'h00, got;
	int n_errors = 0, n_checks = 0, cyc = 0, span = 0;
	// two-way out pin: slave drives it while the master listens
	assign pin = dir ? o2 : sout;
	always #4 clk_sys = ~clk_sys;
	// divide-by-32 tick and hang guard
	always @(posedge clk_sys) begin
		cyc++;
		div32 <= (cyc % 32) == 0;
		if (cyc == 30000) begin n_errors++; tally_and_finish(); end
	end
	gsm_spi_master gsm_spi_master_inst (.clk_sys, .nrst, .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hf), .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_request,
		.core_clock_request(ccr), .serial_clock_pin(sck), .serial_out_pin(sout),
		.out_pin_direction(dir), .receive_path_one(half ? ~o1 : o1), .receive_path_two(pin),
		.core_div32_strobe(div32), .tx_empty_event(txe), .rx_full_event(rxf),
		.dma_write_request(), .dma_read_request());
	// the model always sees a clock that idles low
	gsm_slave_model gsm_slave_model_inst (.sck(sck ^ pol), .mosi(sout),
		.arm, .dual, .reply, .o1, .o2, .got);
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		if (wr) avs_write <= 1'b1; else avs_read <= 1'b1;
		do @(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// one byte: arm the slave, write tx data, wait for rx full, read it
	task automatic xfer(input logic [7:0] tx, input logic [7:0] rep);
		int t;
		t = 0;
		reply <= rep;
		arm <= 1'b1;
		@(posedge clk_sys);
		arm <= 1'b0;
		bus(1, gsm_pkg::OFS_TX_DATA, {24'h0, tx});
		while (rxf !== 1'b1) begin
			@(posedge clk_sys);
			t++;
		end
		span = t;
		bus(0, gsm_pkg::OFS_RX_DATA, 32'h0);
	endtask
	task automatic t_reset();
		`CHK(ccr, 1'b0)
		bus(0, gsm_pkg::OFS_STATUS, 0); `CHK(rd, 32'h1)
		bus(0, gsm_pkg::OFS_ENABLE, 0); `CHK(rd, 32'h0)
		bus(0, 5'h1c, 0); `CHK(rd, 32'h0)
	endtask
	task automatic t_modes();
		bus(1, gsm_pkg::OFS_CLK_DIV, 32'h3);
		bus(1, gsm_pkg::OFS_ENABLE, 1);
		xfer(8'ha5, 8'h3c); `CHK(rd[7:0], 8'h3c)
		`CHK(got, 8'ha5)
		@(posedge clk_sys);
		`CHK(rxf, 1'b0)
		bus(1, gsm_pkg::OFS_CONTROL, 1);
		xfer(8'h01, 8'h12); `CHK(rd[7:0], 8'h48)
		`CHK(got, 8'h80)
		half <= 1'b1;
		bus(1, gsm_pkg::OFS_CONTROL, 32'h2);
		xfer(8'hff, 8'h6b); `CHK(rd[7:0], 8'h6b)
		half <= 1'b0;
		dual <= 1'b1;
		bus(1, gsm_pkg::OFS_CONTROL, 32'h4);
		xfer(8'h00, 8'h96); `CHK(rd[7:0], 8'h96)
		dual <= 1'b0;
		bus(1, gsm_pkg::OFS_CONTROL, 0);
	endtask
	// idle-high clock from the div32 strobe, two ticks per half period
	task automatic t_clock();
		pol <= 1'b1;
		bus(1, gsm_pkg::OFS_CLK_CTRL, 32'hc);
		bus(1, gsm_pkg::OFS_CLK_DIV, 32'h1);
		`CHK(sck, 1'b1)
		xfer(8'h3c, 8'hc3);
		`CHK(rd[7:0], 8'hc3)
		`CHK(got, 8'h3c)
		`CHK(span >= 995 && span <= 1026, 1'b1)
		pol <= 1'b0;
		bus(1, gsm_pkg::OFS_CLK_CTRL, 0);
		bus(1, gsm_pkg::OFS_CLK_DIV, 32'h3);
	endtask
	task automatic t_sleep();
		bus(1, gsm_pkg::OFS_TX_DATA, 32'h5a);
		repeat (2) @(posedge clk_sys);
		sleep_request <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK(ccr, 1'b1)
		repeat (80) @(posedge clk_sys);
		`CHK(rxf, 1'b1)
		`CHK(ccr, 1'b0)
		`CHK(sout, 1'b0)
		sleep_request <= 1'b0;
		@(posedge clk_sys);
		`CHK(ccr, 1'b1)
	endtask
	task automatic t_soft();
		bus(1, gsm_pkg::OFS_CONTROL, 32'h11);
		bus(0, gsm_pkg::OFS_STATUS, 0); `CHK(rd, 32'h1)
		bus(0, gsm_pkg::OFS_CONTROL, 0); `CHK(rd, 32'h0)
		`CHK(ccr, 1'b0)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_modes();
		t_clock();
		t_sleep();
		t_soft();
		tally_and_finish();
	end
endmodule // tb
